// ### design/supply_host_ctrl.sv
// host controller for the supply control and status lines, with an AXI4-Lite register slave
// Operation
// - drive a line low to turn its module off, high to turn it on
// - fresh status needs the request lowered and raised again
// - host releases the module lines within 3 ms of raising the request
// - after request falls, host re-drives lines between 1 and 4 ms later
// - host disregards status of lines with no module fitted
// - global shutdown low turns all outputs off; high lets them run
module supply_host_ctrl
   import supply_host_pkg::*;
#(
   parameter int CYCLES_PER_MS = CYCLES_PER_MS_DEFAULT,
   parameter logic [MS_W-1:0] READ_TIMEOUT_MS = READ_TIMEOUT_MS_DEFAULT
) (
   input wire logic mclk,
   input wire logic rst,
   // axi4-lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // supply interface
   input wire logic [LINES-1:0] moduleLineIn,
   output logic [LINES-1:0] moduleLineOut,
   output logic [LINES-1:0] moduleLineOe,
   output logic globalShutdownN,
   output logic statusReadRequest,
   input wire logic statusDataValid,
   input wire logic acInputGood,
   output logic irq
);
   // ==========================================================
   // declarations
   logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
   logic [1:0] bresp_reg, rresp_reg;
   logic [31:0] rdata_reg;
   logic [7:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic wrEn;
   ctrl_t ctrl_reg;
   logic [LINES-1:0] fitted_reg;
   logic [IRQ_W-1:0] irqMask_reg, irqStatus_reg, irqStatus_next, irqEvents, irqClear;
   logic [LINES-1:0] snapshot_reg;
   logic snapValid_reg;
   seq_state_t state_reg;
   line_drive_t lines_reg;
   logic request_reg, shutdownN_reg, irq_reg, acPrev_reg;
   logic startReq, timerLoad, timerExpired, readDone, readTimeout;
   logic [MS_W-1:0] timerMs;

   // byte-lane merge for writable words
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // ==========================================================
   // axi write channel
   assign wrEn = !awready_reg && !wready_reg && !bvalid_reg;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         awready_reg <= 1'b1;
         wready_reg <= 1'b1;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
         awaddr_reg <= '0;
         wdata_reg <= '0;
         wstrb_reg <= '0;
      end else begin
         if (s_axi_awvalid && awready_reg) begin
            awready_reg <= 1'b0;
            awaddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && wready_reg) begin
            wready_reg <= 1'b0;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
         if (wrEn) begin
            bvalid_reg <= 1'b1;
            unique case (awaddr_reg)
               CTRL_OFS, STATUS_OFS, IRQ_STATUS_OFS, IRQ_MASK_OFS, FITTED_OFS: begin
                  bresp_reg <= RESP_OKAY;
               end
               default: begin
                  bresp_reg <= RESP_SLVERR;
               end
            endcase
         end
         if (bvalid_reg && s_axi_bready) begin
            bvalid_reg <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
         end
      end
   end

   // ==========================================================
   // axi read channel
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
         rdata_reg <= '0;
         rresp_reg <= RESP_OKAY;
      end else if (s_axi_arvalid && arready_reg) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b1;
         rresp_reg <= RESP_OKAY;
         rdata_reg <= '0;
         unique case (s_axi_araddr)
            CTRL_OFS: begin
               rdata_reg[CTRL_SHUTDOWN_BIT:CTRL_ENABLE_LSB] <= ctrl_reg;
            end
            STATUS_OFS: begin
               rdata_reg[ST_SNAPSHOT_LSB +: LINES] <= snapshot_reg;
               rdata_reg[ST_SNAP_VALID_BIT] <= snapValid_reg;
               rdata_reg[ST_BUSY_BIT] <= (state_reg != IDLE);
               rdata_reg[ST_DATA_VALID_BIT] <= statusDataValid;
               rdata_reg[ST_AC_GOOD_BIT] <= acInputGood;
               rdata_reg[ST_DRIVEN_BIT] <= lines_reg.drive[0];
            end
            IRQ_STATUS_OFS: begin
               rdata_reg[IRQ_W-1:0] <= irqStatus_reg;
            end
            IRQ_MASK_OFS: begin
               rdata_reg[IRQ_W-1:0] <= irqMask_reg;
            end
            FITTED_OFS: begin
               rdata_reg[LINES-1:0] <= fitted_reg;
            end
            default: begin
               rresp_reg <= RESP_SLVERR;
            end
         endcase
      end else if (rvalid_reg && s_axi_rready) begin
         rvalid_reg <= 1'b0;
         arready_reg <= 1'b1;
      end
   end

   // ==========================================================
   // control registers
   logic [31:0] ctrlMerged;
   assign ctrlMerged = merge({28'h0000000, ctrl_reg}, wdata_reg, wstrb_reg);
   assign startReq = wrEn && (awaddr_reg == CTRL_OFS) && wstrb_reg[0]
                     && wdata_reg[CTRL_START_BIT];

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctrl_reg <= '{shutdown: 1'b0, enable: ENABLE_RESET};
         fitted_reg <= FITTED_RESET;
         irqMask_reg <= IRQ_MASK_RESET;
      end else if (wrEn) begin
         unique case (awaddr_reg)
            CTRL_OFS: begin
               ctrl_reg <= ctrlMerged[CTRL_SHUTDOWN_BIT:CTRL_ENABLE_LSB];
            end
            IRQ_MASK_OFS: begin
               irqMask_reg <= IRQ_W'(merge({28'h0000000, irqMask_reg}, wdata_reg,
                                           wstrb_reg));
            end
            FITTED_OFS: begin
               fitted_reg <= LINES'(merge({29'h00000000, fitted_reg}, wdata_reg,
                                          wstrb_reg));
            end
            default: begin
            end
         endcase
      end
   end

   // ==========================================================
   // read sequence
   ms_timer #(
      .CYCLES_PER_MS(CYCLES_PER_MS)
   ) u_timer (
      .mclk(mclk),
      .rst(rst),
      .load(timerLoad),
      .loadMs(timerMs),
      .expired(timerExpired)
   );

   assign readDone = (state_reg == READING) && statusDataValid;
   assign readTimeout = (state_reg == READING) && !statusDataValid && timerExpired;
   assign timerLoad = (state_reg == IDLE && startReq) || readDone || readTimeout;
   assign timerMs = (state_reg == IDLE) ? READ_TIMEOUT_MS : RESUME_MS;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_reg <= IDLE;
         request_reg <= 1'b0;
         lines_reg <= '{level: ENABLE_RESET, drive: {LINES{1'b1}}};
         snapshot_reg <= '0;
         snapValid_reg <= 1'b0;
      end else begin
         unique case (state_reg)
            IDLE: begin
               lines_reg.level <= ctrl_reg.enable;
               lines_reg.drive <= {LINES{1'b1}};
               if (startReq) begin
                  state_reg <= READING;
                  request_reg <= 1'b1;
                  lines_reg.drive <= '0;
                  snapValid_reg <= 1'b0;
               end
            end
            READING: begin
               if (readDone) begin
                  snapshot_reg <= moduleLineIn & fitted_reg;
                  snapValid_reg <= 1'b1;
                  request_reg <= 1'b0;
                  state_reg <= RECOVER;
               end else if (readTimeout) begin
                  request_reg <= 1'b0;
                  state_reg <= RECOVER;
               end
            end
            RECOVER: begin
               if (timerExpired) begin
                  lines_reg.level <= ctrl_reg.enable;
                  lines_reg.drive <= {LINES{1'b1}};
                  state_reg <= IDLE;
               end
            end
         endcase
      end
   end

   // global shutdown acts in every state, also while reading
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         shutdownN_reg <= 1'b1;
      end else begin
         shutdownN_reg <= !ctrl_reg.shutdown;
      end
   end

   // ==========================================================
   // interrupts
   always_comb begin
      irqEvents = '0;
      irqEvents[IRQ_READ_DONE] = readDone;
      irqEvents[IRQ_READ_TIMEOUT] = readTimeout;
      irqEvents[IRQ_AC_LOST] = acPrev_reg && !acInputGood;
      irqEvents[IRQ_AC_RESTORED] = !acPrev_reg && acInputGood;
      irqClear = '0;
      if (wrEn && awaddr_reg == IRQ_STATUS_OFS && wstrb_reg[0]) begin
         irqClear = wdata_reg[IRQ_W-1:0];
      end
      irqStatus_next = (irqStatus_reg & ~irqClear) | irqEvents;
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         irqStatus_reg <= '0;
         acPrev_reg <= 1'b0;
         irq_reg <= 1'b0;
      end else begin
         irqStatus_reg <= irqStatus_next;
         acPrev_reg <= acInputGood;
         irq_reg <= |(irqStatus_next & irqMask_reg);
      end
   end

   // ==========================================================
   // outputs
   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
   assign moduleLineOut = lines_reg.level;
   assign moduleLineOe = lines_reg.drive;
   assign globalShutdownN = shutdownN_reg;
   assign statusReadRequest = request_reg;
   assign irq = irq_reg;
endmodule // supply_host_ctrl

// ### design/supply_host_pkg.sv
// package: register map, field layout, timing and types of the supply host controller
package supply_host_pkg;
   // ==========================================================
   // clock and time base
   localparam int CLK_PERIOD_NS = 10;
   localparam int MS_NS = 1000000;
   localparam int CYCLES_PER_MS_DEFAULT = MS_NS / CLK_PERIOD_NS;
   localparam int PRESCALE_W = 17;
   localparam int MS_W = 12;
   // times in milliseconds
   localparam logic [MS_W-1:0] RELEASE_MAX_MS = 12'h003;
   localparam logic [MS_W-1:0] RESUME_MIN_MS = 12'h001;
   localparam logic [MS_W-1:0] RESUME_MAX_MS = 12'h004;
   localparam logic [MS_W-1:0] RESUME_MS = 12'h002;
   localparam logic [MS_W-1:0] READ_TIMEOUT_MS_DEFAULT = 12'h3E8;

   // ==========================================================
   // module lines
   localparam int LINES = 3;

   // ==========================================================
   // register offsets (byte addresses)
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] IRQ_STATUS_OFS = 8'h08;
   localparam logic [7:0] IRQ_MASK_OFS = 8'h0C;
   localparam logic [7:0] FITTED_OFS = 8'h10;

   // ctrl field positions
   localparam int CTRL_ENABLE_LSB = 0;
   localparam int CTRL_SHUTDOWN_BIT = 3;
   localparam int CTRL_START_BIT = 4;
   // status field positions
   localparam int ST_SNAPSHOT_LSB = 0;
   localparam int ST_SNAP_VALID_BIT = 3;
   localparam int ST_BUSY_BIT = 4;
   localparam int ST_DATA_VALID_BIT = 5;
   localparam int ST_AC_GOOD_BIT = 6;
   localparam int ST_DRIVEN_BIT = 7;
   // interrupt bits
   localparam int IRQ_W = 4;
   localparam int IRQ_READ_DONE = 0;
   localparam int IRQ_READ_TIMEOUT = 1;
   localparam int IRQ_AC_LOST = 2;
   localparam int IRQ_AC_RESTORED = 3;

   // reset values
   localparam logic [LINES-1:0] ENABLE_RESET = 3'h7;
   localparam logic [LINES-1:0] FITTED_RESET = 3'h7;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 4'h0;

   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ==========================================================
   // types
   typedef struct packed {
      logic shutdown;
      logic [LINES-1:0] enable;
   } ctrl_t;

   typedef struct packed {
      logic [LINES-1:0] level;
      logic [LINES-1:0] drive;
   } line_drive_t;

   typedef enum logic [1:0] {IDLE, READING, RECOVER} seq_state_t;
endpackage

// ### design/ms_timer.sv
// millisecond countdown timer with a prescaler
module ms_timer
   import supply_host_pkg::*;
#(
   parameter int CYCLES_PER_MS = CYCLES_PER_MS_DEFAULT
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic load,
   input wire logic [MS_W-1:0] loadMs,
   output logic expired
);
   localparam logic [PRESCALE_W-1:0] RELOAD = PRESCALE_W'(CYCLES_PER_MS - 1);

   logic [PRESCALE_W-1:0] pre_reg;
   logic [MS_W-1:0] cnt_reg;
   logic expired_reg;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pre_reg <= '0;
         cnt_reg <= '0;
         expired_reg <= 1'b0;
      end else if (load) begin
         pre_reg <= RELOAD;
         cnt_reg <= loadMs;
         expired_reg <= 1'b0;
      end else if (cnt_reg != '0) begin
         if (pre_reg == '0) begin
            pre_reg <= RELOAD;
            cnt_reg <= cnt_reg - 1'b1;
            if (cnt_reg == 12'h001) begin
               expired_reg <= 1'b1;
            end
         end else begin
            pre_reg <= pre_reg - 1'b1;
         end
      end
   end

   assign expired = expired_reg;
endmodule // ms_timer

// ### verif/supply_host_ctrl_sva.sv
// checker: port timing of the supply host controller
module supply_host_ctrl_sva
   import supply_host_pkg::*;
#(
   parameter int CYCLES_PER_MS = CYCLES_PER_MS_DEFAULT,
   parameter logic [MS_W-1:0] READ_TIMEOUT_MS = READ_TIMEOUT_MS_DEFAULT
) (
   input logic mclk,
   input logic rst,
   input logic s_axi_awvalid,
   input logic s_axi_awready,
   input logic s_axi_wvalid,
   input logic s_axi_wready,
   input logic s_axi_bvalid,
   input logic s_axi_bready,
   input logic [1:0] s_axi_bresp,
   input logic s_axi_arvalid,
   input logic s_axi_arready,
   input logic s_axi_rvalid,
   input logic s_axi_rready,
   input logic [31:0] s_axi_rdata,
   input logic [LINES-1:0] moduleLineOe,
   input logic statusReadRequest,
   input logic statusDataValid
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int REQ_LIMIT = int'(READ_TIMEOUT_MS) * CYCLES_PER_MS + 4;
   int gap;
   int reqLen;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // =====
   // counts: cycles released after the request fell, cycles the request is high
   always_ff @(posedge mclk or posedge rst) begin
      if (rst)
         gap <= 0;
      else if (moduleLineOe == 3'h7)
         gap <= 0;
      else if (!statusReadRequest)
         gap <= gap + 1;
   end
   always_ff @(posedge mclk or posedge rst) begin
      if (rst)
         reqLen <= 0;
      else
         reqLen <= statusReadRequest ? reqLen + 1 : 0;
   end
   // =====
   // assertions
   a_release_with_request:
      assert property ($rose(statusReadRequest) |-> moduleLineOe == 3'h0) else $error("lines held");
   a_released_in_read:
      assert property (statusReadRequest |-> moduleLineOe == 3'h0) else $error("driven in read");
   a_resume_window:
      assert property ($rose(moduleLineOe[0]) |-> gap >= CYCLES_PER_MS && gap <= 4 * CYCLES_PER_MS)
         else $error("resume outside window");
   a_start_from_idle:
      assert property ($rose(statusReadRequest) |-> $past(moduleLineOe) == 3'h7)
         else $error("read started while released");
   a_drop_after_valid:
      assert property (statusReadRequest && statusDataValid |=> !statusReadRequest)
         else $error("request kept after valid");
   a_read_bounded:
      assert property (statusReadRequest |-> reqLen <= REQ_LIMIT) else $error("read too long");
   a_lines_whole:
      assert property (moduleLineOe == 3'h0 || moduleLineOe == 3'h7) else $error("partial drive");
   a_bresp_holds:
      assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
         else $error("write response dropped");
   a_rdata_holds:
      assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
         else $error("read data dropped");
   a_write_answer:
      assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
         |-> ##2 s_axi_bvalid) else $error("no write response");
   a_read_answer:
      assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read data");
   c_read: cover property ($rose(statusReadRequest));
   c_valid: cover property (statusReadRequest && statusDataValid);
   c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // supply_host_ctrl_sva

bind supply_host_ctrl supply_host_ctrl_sva #(
   .CYCLES_PER_MS(CYCLES_PER_MS),
   .READ_TIMEOUT_MS(READ_TIMEOUT_MS)
) u_sva (
   .mclk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
   .s_axi_rdata, .moduleLineOe, .statusReadRequest, .statusDataValid
);

// ### verif/supply_model.sv
// behavioural supply: module switching, one-shot status read, ac input status
module supply_model #(
   parameter int MEASURE = 2000
) (
   input wire logic mclk,
   input wire logic [2:0] hostLevel,
   input wire logic [2:0] hostOe,
   input wire logic shutdownN,
   input wire logic readReq,
   input wire logic [2:0] fault,
   input wire logic mute,
   input wire logic quick,
   input wire logic acIn,
   output logic [2:0] lineLevel,
   output logic dataValid,
   output logic acGood,
   output logic [2:0] moduleOn
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] snap = 3'h0;
   logic reqDly = 1'b0;
   int cnt = 0;
   // =====
   // released lines float high outside a read, which the modules take as enable; during a read they carry the status snapshot
   assign lineLevel = (hostOe & hostLevel) | (~hostOe & (readReq ? snap : 3'h7));
   always @(posedge mclk) begin
      reqDly <= readReq;
      if (!shutdownN)
         moduleOn <= 3'h0;
      else if (!readReq)
         moduleOn <= lineLevel;
      if (readReq && !reqDly)
         snap <= moduleOn & ~fault;
      cnt <= (readReq && reqDly) ? cnt + 1 : 0;
   end
   assign dataValid = readReq && !mute && cnt >= (quick ? 2 : MEASURE);
   // outputs ride through the loss of ac status
   assign acGood = acIn;
endmodule // supply_model

// ### verif/supply_host_ctrl_tb_top.sv
// testbench: supply host controller against a behavioural supply
module supply_host_ctrl_tb_top;
   import supply_host_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int CPM = 10;
   logic mclk, rst;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [LINES-1:0] moduleLineIn, moduleLineOut, moduleLineOe, fault, moduleOn;
   logic globalShutdownN, statusReadRequest, statusDataValid, acInputGood, irq, mute, quick, acIn;
   int errors = 0;
   int total_checks = 0;
   int expQ[$];
   supply_host_ctrl #(.CYCLES_PER_MS(CPM), .READ_TIMEOUT_MS(12'h12C)) DUT (
      .mclk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .moduleLineIn, .moduleLineOut, .moduleLineOe, .globalShutdownN, .statusReadRequest,
      .statusDataValid, .acInputGood, .irq);
   supply_model #(.MEASURE(200 * CPM)) supply (
      .mclk, .hostLevel(moduleLineOut), .hostOe(moduleLineOe), .shutdownN(globalShutdownN),
      .readReq(statusReadRequest), .fault, .mute, .quick, .acIn, .lineLevel(moduleLineIn),
      .dataValid(statusDataValid), .acGood(acInputGood), .moduleOn);
   // =====
   // tasks
   task automatic wrap_up();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t %s got %0h expected %0h", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      bit aw = 0;
      bit w = 0;
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      while (!(aw && w)) begin
         @(posedge mclk);
         aw |= s_axi_awready;
         w |= s_axi_wready;
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
      end
      do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk(s_axi_bresp, er, "write response");
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      @(posedge mclk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do @(posedge mclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      chk(s_axi_rresp, a < 8'h14 ? RESP_OKAY : RESP_SLVERR, "read response");
      chk(s_axi_rdata & m, e, "read data");
   endtask
   task automatic wait_irq();
      int n = 0;
      while (irq !== 1'b1 && n < 5000) begin
         @(posedge mclk);
         n++;
      end
      chk(irq, 1'b1, "interrupt");
   endtask
   // =====
   // clock, watchdog, tests
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial begin
      #300000;
      errors++;
      wrap_up();
   end
   initial begin
      int seed, en, f;
      rst = 1'b1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'hF;
      {fault, mute, quick, acIn} = 6'h1;
      seed = $urandom(82);
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      chk(moduleLineOe, 3'h7, "lines driven after reset");
      rdchk(CTRL_OFS, 32'hFFFFFFFF, 32'h7);
      rdchk(FITTED_OFS, 32'h7, 32'h7);
      rdchk(IRQ_MASK_OFS, 32'hF, 32'h0);
      rdchk(8'h14, 32'hFFFFFFFF, 32'h0);
      wr(8'h14, 32'hF, RESP_SLVERR);
      wr(IRQ_STATUS_OFS, 32'hF, RESP_OKAY);
      rdchk(IRQ_STATUS_OFS, 32'hF, 32'h0);
      for (int i = 0; i < 9; i++) begin
         wr(CTRL_OFS, i == 8 ? 32'hF : 32'(i), RESP_OKAY);
         repeat (3) @(posedge mclk);
         chk(moduleOn, i == 8 ? 0 : i, "module enables");
      end
      wr(IRQ_MASK_OFS, 32'hF, RESP_OKAY);
      for (int k = 0; k < 3; k++) begin
         en = $urandom % 8;
         f = $urandom % 8;
         fault <= f[2:0];
         quick <= k[0];
         wr(CTRL_OFS, en, RESP_OKAY);
         repeat (3) @(posedge mclk);
         expQ.push_back(en & ~f & 7);
         wr(CTRL_OFS, en | 16, RESP_OKAY);
         rdchk(STATUS_OFS, 32'h90, 32'h10);
         if (k == 2) begin
            wr(CTRL_OFS, 32'h0, RESP_OKAY);
            chk(moduleOn, en, "disable ignored in read");
            wr(CTRL_OFS, 32'h8, RESP_OKAY);
            repeat (3) @(posedge mclk);
            chk(moduleOn, 0, "shutdown in read");
            en = 0;
         end
         wait_irq();
         rdchk(STATUS_OFS, 32'hEF, 32'h48 | expQ.pop_front());
         rdchk(IRQ_STATUS_OFS, 32'hF, 32'h1);
         wr(IRQ_STATUS_OFS, 32'h1, RESP_OKAY);
         @(posedge mclk);
         chk(irq, 1'b0, "irq cleared");
         repeat (6 * CPM) @(posedge mclk);
         chk(moduleOn, en, "enables after read");
      end
      mute <= 1'b1;
      wr(CTRL_OFS, 32'h17, RESP_OKAY);
      wait_irq();
      rdchk(IRQ_STATUS_OFS, 32'hF, 32'h2);
      rdchk(STATUS_OFS, 32'h8, 32'h0);
      mute <= 1'b0;
      wr(IRQ_MASK_OFS, 32'h0, RESP_OKAY);
      acIn <= 1'b0;
      repeat (3) @(posedge mclk);
      chk(irq, 1'b0, "masked interrupt");
      rdchk(IRQ_STATUS_OFS, 32'h4, 32'h4);
      rdchk(STATUS_OFS, 32'h40, 32'h0);
      chk(moduleOn, 3'h7, "outputs held up");
      wr(IRQ_MASK_OFS, 32'h4, RESP_OKAY);
      repeat (2) @(posedge mclk);
      chk(irq, 1'b1, "unmasked interrupt");
      wrap_up();
   end
endmodule // supply_host_ctrl_tb_top
